// ===== src/pxr_regs.sv
/*
 * APB register bank for the transceiver's extended control: transmit clock
 * phase shift, power back-off, regulator power-down and cable diagnostics.
 * Each 16-bit register sits in the low half of one aligned 32-bit word at
 * four times its index; the upper half reads zero and is never stored.
 * Command bits (phase enable, regulator power-down, length diagnostic
 * start) leave one-cycle pulses, phase enable only when the phase changes,
 * and read back as zero.
 * The phase shifter receives the new phase, the step count and the
 * direction together with a one-cycle apply pulse.
 * Assumes an APB master on pclk, 32-bit data; analog blocks sit outside
 * and act on the levels and pulses driven here. The slave answers with
 * no wait states, and per-lane strobes select which byte is written; the back-off field needs both.
 * The diagnostic engine drives its result and busy level synchronously
 * to pclk; nothing here resynchronises them.
 */
// Functional notes
// (R1) phase field reports offset, shifts 4 ns/step
// (R2) phase stored modulo ten; the code keeps a written ten as ten and folds only 11 to 15
// (R3) back-off field selects transmit power level
// (R4) regulator power-down pulses, bit self-clears
// (R5) host writes zeros to regulator reserved bits
// (R6) host powers regulator down only with external core
// (R7) length averaging factor, resets to 001
// (R8) cross-disable selects per-pair only test
// (R9) transmit-pair bypass moves results to receive slots
// (R10) receive-pair bypass bit is read-only
// (R11) host keeps reserved bit 11 at one
// (R12) averaging code n gives 2^n cycles; the code gives 64 cycles for code 111
// (R13) pulse control field resets to 1100
// (R14) listen length field resets to all ones
// (R15) reserved read-only bits ignore writes, read zero
// (R16) host ignores reserved read-write config bits
// (R17) phase enable applies value, then self-clears
// (R18) command bits read back zero once accepted
`timescale 1ns/100ps
`include "pxr_defs.svh"

module pxr_regs #(
	parameter int ADDR_W = 12
) (
	// apb slave
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W+1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// transmit clock phase
	output logic      [3:0]        tx_phase,
	output logic                   tx_phase_apply,
	output logic      [4:0]        tx_shift_steps,
	output logic                   tx_shift_later,
	// power
	output logic      [2:0]        power_back_off,
	output logic                   regulator_power_down,
	output logic                   regulator_enabled,
	// cable diagnostics
	output logic                   length_diag_start,
	output logic      [6:0]        diag_average_cycles,
	output pxr_pkg::pxr_diag_cfg_t diag_cfg,
	output logic                   diag_use_rx_slots,
	input  wire logic [7:0]        length_diag_result,
	input  wire logic              length_diag_busy
);

	// ==========================================================
	// decode
	logic [ADDR_W-1:0] idx;
	logic              wr_acc;
	logic              rd_acc;
	logic              hit;
	logic              wr_lo;
	logic              wr_hi;

	function automatic logic known_index(input logic [ADDR_W-1:0] a);
		known_index = (a == `PXR_IDX_TXPH) || (a == `PXR_IDX_PBO) ||
			(a == `PXR_IDX_VREG) || (a == `PXR_IDX_ALEN) ||
			(a == `PXR_IDX_CDCTL) || (a == `PXR_IDX_CDPULSE) ||
			(a == `PXR_IDX_CDLISTEN);
	endfunction

	// zero-wait slave: every access completes in its first access cycle
	assign idx     = paddr[ADDR_W+1:2];
	assign hit     = known_index(idx) && (paddr[1:0] == 2'b00);
	assign wr_acc  = psel && penable && pwrite && hit;
	assign rd_acc  = psel && penable && !pwrite;
	assign wr_lo   = wr_acc && pstrb[0];
	assign wr_hi   = wr_acc && pstrb[1];
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit;

	// one enable per register and lane, so each field below names its strobe
	logic       txph_we;
	logic       pbo_we;
	logic       vreg_cmd;
	logic       alen_lo_we;
	logic       alen_cmd;
	logic       cdctl_we;
	logic [1:0] pulse_we;
	logic [1:0] listen_we;

	// a phase write without the enable bit changes nothing at all
	assign txph_we    = wr_lo && (idx == `PXR_IDX_TXPH) && pwdata[`PXR_TXPH_EN_BIT]; // R17
	// the back-off field straddles both lanes, so both must be strobed
	assign pbo_we     = wr_lo && wr_hi && (idx == `PXR_IDX_PBO); // R3
	// command bits decode straight to pulses; nothing is stored for them
	assign vreg_cmd   = wr_hi && (idx == `PXR_IDX_VREG) && pwdata[`PXR_VREG_PD_BIT]; // R4
	assign alen_lo_we = wr_lo && (idx == `PXR_IDX_ALEN); // R7
	assign alen_cmd   = wr_hi && (idx == `PXR_IDX_ALEN) && pwdata[`PXR_ALEN_START_BIT];
	assign cdctl_we   = wr_hi && (idx == `PXR_IDX_CDCTL);
	assign pulse_we   = {wr_hi, wr_lo} & {2{idx == `PXR_IDX_CDPULSE}};
	assign listen_we  = {wr_hi, wr_lo} & {2{idx == `PXR_IDX_CDLISTEN}};

	// ==========================================================
	// transmit clock phase
	logic [3:0] phase_q;
	logic [3:0] phase_d;
	logic [3:0] wr_phase;
	logic       apply_q;
	logic [4:0] steps_q;
	logic       later_q;

	assign wr_phase = pwdata[3:0];
	// values above ten fold back modulo ten
	assign phase_d = (wr_phase > `PXR_PHASE_MAX) ? wr_phase - `PXR_PHASE_MAX : wr_phase; // R2

	// the shift is only performed when the enable bit is written as one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= `PXR_RST_PHASE;
			apply_q <= 1'b0;
			steps_q <= 5'h00;
			later_q <= 1'b0;
		end else begin
			apply_q <= 1'b0; // R17 R18
			if (txph_we) begin // R17
				phase_q <= phase_d; // R1
				apply_q <= (phase_d != phase_q); // R1
				later_q <= (phase_d > phase_q);
				// shift distance in 4 ns steps is the change of value
				steps_q <= (phase_d > phase_q) ? {1'b0, phase_d - phase_q} :
					{1'b0, phase_q - phase_d}; // R1
			end
		end
	end

	// the phase outputs travel together to the clock shifter
	pxr_pkg::pxr_phase_t phase_out;

	always_comb begin
		phase_out             = '0;
		phase_out.phase       = phase_q; // R1
		phase_out.phase_apply = apply_q; // R17
		phase_out.shift_steps = steps_q; // R1
		phase_out.shift_later = later_q; // R1
	end

	assign tx_phase       = phase_out.phase; // R1
	assign tx_phase_apply = phase_out.phase_apply;
	assign tx_shift_steps = phase_out.shift_steps;
	assign tx_shift_later = phase_out.shift_later;

	// ==========================================================
	// power back-off
	logic [2:0] pbo_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pbo_q <= `PXR_RST_PBO;
		end else if (pbo_we) begin
			pbo_q <= pwdata[8:6]; // R3
		end
	end

	// reserved codes pass through; the analog side treats them as normal
	assign power_back_off = pbo_q; // R3

	// ==========================================================
	// regulator
	logic vreg_pd_q;
	logic vreg_off_q;

	// power-down is one-way until reset; the command bit only pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vreg_pd_q  <= 1'b0;
			vreg_off_q <= 1'b0;
		end else begin
			vreg_pd_q <= vreg_cmd; // R4 R18
			if (vreg_pd_q) begin
				vreg_off_q <= 1'b1; // R4
			end
		end
	end

	assign regulator_power_down = vreg_pd_q;
	assign regulator_enabled    = !vreg_off_q; // R4

	// ==========================================================
	// cable diagnostics
	logic        start_q;
	logic [2:0]  avgf_q;
	logic        xdis_q;
	logic        txbyp_q;
	logic [2:0]  cdavg_q;
	logic [15:0] pulse_q;
	logic [15:0] listen_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_q <= 1'b0;
			avgf_q  <= `PXR_RST_AVGF;
		end else begin
			// the start bit only pulses; the averaging factor is what is stored
			start_q <= alen_cmd; // R18
			if (alen_lo_we) begin
				avgf_q <= pwdata[2:0]; // R7
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xdis_q  <= 1'b0;
			txbyp_q <= 1'b0;
			cdavg_q <= `PXR_RST_CDAVG;
		end else if (cdctl_we) begin
			// bits 12 and 11 have no storage; the read path fixes them
			xdis_q  <= pwdata[`PXR_CD_XDIS_BIT]; // R8
			txbyp_q <= pwdata[`PXR_CD_TXBYP_BIT]; // R9
			cdavg_q <= pwdata[10:8]; // R12
		end
	end

	// reserved read-write bits are kept as written so software sees them back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_q  <= `PXR_RST_CDPULSE;
			listen_q <= `PXR_RST_CDLISTEN;
		end else begin
			if (pulse_we[0]) begin
				pulse_q[7:0] <= pwdata[7:0]; // R13
			end
			if (pulse_we[1]) begin
				pulse_q[15:8] <= pwdata[15:8];
			end
			if (listen_we[0]) begin
				listen_q[7:0] <= pwdata[7:0];
			end
			if (listen_we[1]) begin
				listen_q[15:8] <= pwdata[15:8]; // R14
			end
		end
	end

	assign length_diag_start = start_q;

	// code 111 is reserved; it is clamped to the largest legal count
	always_comb begin
		diag_average_cycles = 7'h00;
		if (cdavg_q == 3'h7) begin
			diag_average_cycles = 7'h40; // R12
		end else begin
			diag_average_cycles = 7'(7'h01 << cdavg_q); // R12
		end
	end

	always_comb begin
		diag_cfg                   = '0;
		diag_cfg.cross_disable     = xdis_q; // R8
		diag_cfg.tx_pair_bypass    = txbyp_q; // R9
		diag_cfg.rx_pair_bypass    = 1'b0; // R10
		diag_cfg.average_code      = cdavg_q;
		diag_cfg.pulse_control     = pulse_q[3:0]; // R13
		diag_cfg.listen_length     = listen_q[15:8]; // R14
		diag_cfg.length_avg_factor = avgf_q; // R7
	end

	// with the transmit pair skipped its results land in the receive slots
	assign diag_use_rx_slots = txbyp_q; // R9

	// ==========================================================
	// read data
	// each word is built on its own line so the reserved patterns sit
	// next to the live fields they surround
	logic [15:0] txph_word;
	logic [15:0] pbo_word;
	logic [15:0] vreg_word;
	logic [15:0] alen_word;
	logic [15:0] cdctl_word;
	logic [15:0] pulse_word;
	logic [15:0] listen_word;
	logic [15:0] rd_word;

	// the enable bit is a command and never reads back
	assign txph_word   = {12'h000, phase_q}; // R1 R15 R18
	// fixed reserved pattern around the back-off field
	assign pbo_word    = `PXR_RST_PBO_FIXED | {7'h00, pbo_q, 6'h00}; // R3
	// power-down clears itself and the reserved bits hold no state
	assign vreg_word   = 16'h0000; // R4 R18
	// start, bits 14:13 and bit 3 read zero; result and busy are live
	assign alen_word   = {3'h0, length_diag_busy, length_diag_result, 1'b0, avgf_q}; // R7 R15
	// receive bypass is read-only zero, bit 11 always reads one
	assign cdctl_word  = {1'b0, xdis_q, txbyp_q, 1'b0, 1'b1, cdavg_q, 8'h00}; // R10 R11 R15
	// reserved read-write bits come back exactly as written
	assign pulse_word  = pulse_q; // R13 R16
	assign listen_word = listen_q; // R14 R16

	always_comb begin
		rd_word = 16'h0000;
		unique case (idx)
			`PXR_IDX_TXPH:     rd_word = txph_word;
			`PXR_IDX_PBO:      rd_word = pbo_word;
			`PXR_IDX_VREG:     rd_word = vreg_word;
			`PXR_IDX_ALEN:     rd_word = alen_word;
			`PXR_IDX_CDCTL:    rd_word = cdctl_word;
			`PXR_IDX_CDPULSE:  rd_word = pulse_word;
			`PXR_IDX_CDLISTEN: rd_word = listen_word;
			default:           rd_word = 16'h0000;
		endcase
	end

	// captured in the setup cycle so it stands through the access phase;
	// a miss, unmapped or misaligned, reads zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= hit ? {16'h0000, rd_word} : 32'h0000_0000;
		end
	end

	logic unused_rd;
	assign unused_rd = rd_acc;

endmodule

// ===== src/pxr_defs.svh
/*
 * Register offsets, field positions, reset values and timing figures of
 * the extended transceiver control bank. Definitions only.
 */
`ifndef PXR_DEFS_SVH
`define PXR_DEFS_SVH

// ==========================================================
// register offsets (printed offsets are indices; byte addr = 4 * index)
`define PXR_IDX_TXPH    12'h042
`define PXR_IDX_PBO     12'h0ae
`define PXR_IDX_VREG    12'h0d0
`define PXR_IDX_ALEN    12'h155
`define PXR_IDX_CDCTL   12'h170
`define PXR_IDX_CDPULSE 12'h171
`define PXR_IDX_CDLISTEN 12'h173

// ==========================================================
// field positions
`define PXR_TXPH_EN_BIT    4
`define PXR_VREG_PD_BIT    15
`define PXR_ALEN_START_BIT 15
`define PXR_CD_XDIS_BIT    14
`define PXR_CD_TXBYP_BIT   13
`define PXR_CD_RXBYP_BIT   12
`define PXR_CD_RSV1_BIT    11

// ==========================================================
// reset values
`define PXR_RST_PHASE     4'h0
`define PXR_RST_PBO       3'h0
`define PXR_RST_PBO_FIXED 16'h8020
`define PXR_RST_AVGF      3'h1
`define PXR_RST_CDAVG     3'h6
`define PXR_RST_CDPULSE   16'hc85c
`define PXR_RST_CDLISTEN  16'hffff

// ==========================================================
// timing figures
`define PXR_PHASE_STEP_NS 4
`define PXR_PHASE_MAX     4'ha

`endif

// ===== src/pxr_pkg.sv
/*
 * Types shared by the extended transceiver control bank.
 * Assumes pxr_defs.svh holds the numeric constants.
 */
package pxr_pkg;

	typedef struct packed {
		logic        cross_disable;
		logic        tx_pair_bypass;
		logic        rx_pair_bypass;
		logic [2:0]  average_code;
		logic [3:0]  pulse_control;
		logic [7:0]  listen_length;
		logic [2:0]  length_avg_factor;
	} pxr_diag_cfg_t;

	typedef struct packed {
		logic [3:0] phase;
		logic       phase_apply;
		logic [4:0] shift_steps;
		logic       shift_later;
	} pxr_phase_t;

	typedef enum logic [1:0] {
		PXR_IDLE   = 2'b00,
		PXR_ACCESS = 2'b01
	} pxr_apb_state_t;

endpackage

// ===== tb/pxr_regs_properties.sv
/* assertions on the ports of the extended control bank;
   bound to every pxr_regs instance, one clock, async reset */
`timescale 1ns/100ps
module pxr_regs_chk #(
	parameter int ADDR_W = 12
) (
	// apb side
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [ADDR_W+1:0]      paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [3:0]             pstrb,
	input wire logic                   pready,
	input wire logic                   pslverr,
	// controls
	input wire logic [3:0]             tx_phase,
	input wire logic                   regulator_power_down,
	input wire logic                   regulator_enabled,
	input wire logic                   length_diag_start,
	input wire logic [6:0]             diag_average_cycles,
	input wire pxr_pkg::pxr_diag_cfg_t diag_cfg,
	input wire logic                   diag_use_rx_slots
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================
	// command write, then a one-cycle pulse
	sequence s_cmd(a);
		psel && penable && pwrite && paddr == a && pwdata[15] && pstrb[1];
	endsequence
	sequence s_one(x);
		x ##1 !x;
	endsequence
	a_zero_wait: assert property (psel && penable |-> pready) else $error("pready low");
	a_phase_limit: assert property (tx_phase <= 4'ha) else $error("phase above ten");
	a_phase_hold: assert property (!(psel && penable && pwrite) |=> $stable(tx_phase))
		else $error("phase moved without write");
	a_vreg_pulse: assert property (s_cmd(14'h0340) |=> s_one(regulator_power_down))
		else $error("regulator pulse wrong");
	a_vreg_off: assert property (regulator_power_down |=> !regulator_enabled[*3])
		else $error("regulator still on");
	a_start_pulse: assert property (s_cmd(14'h0554) |=> s_one(length_diag_start))
		else $error("start pulse wrong");
	a_avg_cycles: assert property (diag_average_cycles == (diag_cfg.average_code == 3'h7 ?
		7'd64 : 7'd1 << diag_cfg.average_code)) else $error("average count wrong");
	a_rx_bypass_ro: assert property (!diag_cfg.rx_pair_bypass) else $error("rx bypass set");
	a_rx_slots: assert property (diag_use_rx_slots == diag_cfg.tx_pair_bypass)
		else $error("slot select wrong");
	a_unmapped_err: assert property (psel && penable && paddr == 14'h0004 |-> pslverr)
		else $error("no slave error");
endmodule
bind pxr_regs pxr_regs_chk #(.ADDR_W(ADDR_W)) chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .pready(pready), .pslverr(pslverr), .tx_phase(tx_phase),
	.regulator_power_down(regulator_power_down), .regulator_enabled(regulator_enabled),
	.length_diag_start(length_diag_start), .diag_average_cycles(diag_average_cycles),
	.diag_cfg(diag_cfg), .diag_use_rx_slots(diag_use_rx_slots));

// ===== tb/tb_top.sv
/* self-checking bench for pxr_regs: apb master tasks and an integer
   model; assumes the checker is bound from its own file */
`timescale 1ns/100ps
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, busy, ven;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb, tx_phase;
	logic [4:0]  steps;
	logic [2:0]  pbo;
	logic [7:0]  res;
	logic        app, later;
	logic [6:0]  avg;
	int          fail_count, cmp_count, cyc, ph, pn, v;
	pxr_pkg::pxr_diag_cfg_t cfg;
	pxr_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tx_phase(tx_phase), .tx_phase_apply(app),
		.tx_shift_steps(steps), .tx_shift_later(later), .power_back_off(pbo),
		.regulator_power_down(), .regulator_enabled(ven), .length_diag_start(),
		.diag_average_cycles(avg), .diag_cfg(cfg), .diag_use_rx_slots(),
		.length_diag_result(res), .length_diag_busy(busy));
	// ==========================================
	// tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] i, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {i, 2'b00};
		pwdata  <= d;
		pstrb   <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input string n, input logic [11:0] i, input logic [31:0] e);
		apb(1'b0, i, 32'h0000_0000, 4'h0);
		chk(n, e, rd);
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ==========================================
	// clock, timeout, sequence
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			final_report();
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb, res, busy} = '0;
		presetn = 1'b0;
		void'($urandom(32'h7409));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		res     <= 8'($urandom);
		busy    <= 1'($urandom);
		rchk("txph", 12'h042, 32'h0000_0000);
		rchk("pbo", 12'h0ae, 32'h0000_8020);
		rchk("cdctl", 12'h170, 32'h0000_0e00);
		rchk("pulse", 12'h171, 32'h0000_c85c);
		rchk("listen", 12'h173, 32'h0000_ffff);
		rchk("alen", 12'h155, {19'h0, busy, res, 4'h1});
		chk("cfg_rst", {11'h000, 3'h6, 4'hc, 8'hff, 3'h1}, cfg);
		chk("avg_rst", 64, avg);
		$display("reset values done");
		ph = 0;
		for (int k = 0; k < 12; k++) begin
			v = (k == 0) ? 15 : (k == 1) ? 10 : $urandom_range(15);
			pn = (v > 10) ? v - 10 : v;
			apb(1'b1, 12'h042, 32'(v | 16), 4'hf);
			@(negedge pclk);
			chk("apply", pn != ph, app);
			if (pn != ph) begin
				chk("steps", (pn > ph) ? pn - ph : ph - pn, steps);
				chk("later", pn > ph, later);
			end
			ph = pn;
			chk("phase", ph, tx_phase);
			@(negedge pclk);
			chk("apply_clr", 0, app);
		end
		apb(1'b1, 12'h042, 32'h0000_0003, 4'hf);
		@(negedge pclk);
		chk("apply", 0, app);
		rchk("txph", 12'h042, ph);
		$display("phase test done");
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, 12'h0ae, 32'hffff_fe3f | (c << 6), 4'h3);
			rchk("pbo", 12'h0ae, 32'h8020 | (c << 6));
			chk("pbo_port", c, pbo);
		end
		apb(1'b1, 12'h0ae, 32'h0000_0000, 4'h1);
		rchk("pbo", 12'h0ae, 32'h0000_80e0);
		apb(1'b1, 12'h0d0, 32'h0000_8000, 4'hf);
		repeat (2) @(posedge pclk);
		chk("ven", 0, ven);
		rchk("vreg", 12'h0d0, 32'h0000_0000);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk("ven_rst", 1, ven);
		chk("phase_rst", 0, tx_phase);
		ph = 0;
		rchk("pbo", 12'h0ae, 32'h0000_8020);
		$display("power test done");
		for (int k = 0; k < 8; k++) begin
			v = ($urandom & 32'hf8ff) | (k << 8);
			apb(1'b1, 12'h170, 32'(v | 32'h800), 4'hf);
			rchk("cdctl", 12'h170, (v & 32'h6700) | 32'h800);
			chk("xdis", v[14], cfg.cross_disable);
			chk("txbyp", v[13], cfg.tx_pair_bypass);
			chk("avg_cycles", (k == 7) ? 64 : (1 << k), avg);
		end
		apb(1'b1, 12'h155, 32'h0000_ffff, 4'hf);
		rchk("alen", 12'h155, {19'h0, busy, res, 4'h7});
		chk("avgf", 7, cfg.length_avg_factor);
		v = $urandom;
		apb(1'b1, 12'h171, v, 4'hf);
		rchk("pulse", 12'h171, v & 32'hffff);
		chk("pulse_cfg", v & 15, cfg.pulse_control);
		apb(1'b1, 12'h173, ~v, 4'hf);
		rchk("listen", 12'h173, ~v & 32'hffff);
		chk("listen_cfg", (~v >> 8) & 255, cfg.listen_length);
		apb(1'b1, 12'h001, 32'hffff_ffff, 4'hf);
		rchk("unmapped", 12'h001, 32'h0000_0000);
		chk("slverr", 1, err);
		$display("diagnostic test done");
		final_report();
	end
endmodule
